// File: design/rx_mac_cfg_map.svh
// Offsets, field positions, reset values and identity words of the receive MAC register bank
`ifndef RX_MAC_CFG_MAP_SVH
`define RX_MAC_CFG_MAP_SVH

// Register indices; byte address is four times the index
`define RXC_IDX_REVISION      11'h500
`define RXC_IDX_TEST_WORD     11'h501
`define RXC_IDX_IDENT_FIRST   11'h502
`define RXC_IDX_IDENT_NEXT    11'h503
`define RXC_IDX_IDENT_FINAL   11'h504
`define RXC_IDX_MAX_LEN       11'h506
`define RXC_IDX_CRC_FWD       11'h507
`define RXC_IDX_FAULT_STAT    11'h508
`define RXC_IDX_LEN_CHECK     11'h50A
`define RXC_IDX_OVR_CNT_LO    11'h50B
`define RXC_IDX_OVR_CNT_HI    11'h50C
`define RXC_IDX_OCT_CNT_LO    11'h50D
`define RXC_IDX_OCT_CNT_HI    11'h50E
`define RXC_IDX_IRQ_STATUS    11'h510
`define RXC_IDX_IRQ_MASK      11'h511

// Reset values
`define RXC_TEST_WORD_RST     32'h0000_0000
`define RXC_MAX_LEN_RST       16'h2580
`define RXC_CRC_FWD_RST       1'h0
`define RXC_LEN_CHECK_RST     1'h1
`define RXC_IRQ_MASK_RST      3'h0

// Identity words, values arbitrary
`define RXC_REVISION_VAL      32'h0000_0001
`define RXC_IDENT_FIRST_VAL   32'h7278_6366
`define RXC_IDENT_NEXT_VAL    32'h675F_626C
`define RXC_IDENT_FINAL_VAL   32'h6F63_6B30

// Per-frame error vector bits
`define RXC_ERR_CRC_BIT       1
`define RXC_ERR_OVERSIZE_BIT  3
`define RXC_ERR_LENGTH_BIT    4

// Event bits of the interrupt status and mask registers
`define RXC_EV_OVERSIZE       0
`define RXC_EV_CRC            1
`define RXC_EV_LENGTH         2

`endif

// File: design/rx_mac_cfg_pkg.sv
// Types shared by the receive MAC register bank
package rx_mac_cfg_pkg;
	typedef logic [15:0] frame_len_t;
	typedef logic [5:0]  rx_err_t;
	typedef logic [63:0] stat_count_t;
	typedef logic [10:0] reg_idx_t;
	typedef logic [2:0]  event_vec_t;
endpackage : rx_mac_cfg_pkg

// File: design/stat_cnt_if.sv
// Increment request and count value between the bank and a statistics counter
`timescale 1ns/1ps
interface stat_cnt_if;
	import rx_mac_cfg_pkg::*;
	logic        inc;
	frame_len_t  amount;
	stat_count_t value;
	modport src (output inc, output amount, input value);
	modport cnt (input inc, input amount, output value);
endinterface : stat_cnt_if

// File: design/rx_stat_counter.sv
// 64-bit statistics counter, held at zero when statistics are not built in
`timescale 1ns/1ps
module rx_stat_counter
	import rx_mac_cfg_pkg::*;
#(
	parameter bit ENABLE = 1'b1
) (
	input  wire logic i_core_clk,
	input  wire logic i_rst_n,
	stat_cnt_if.cnt   cnt
);
	stat_count_t count_q;
	stat_count_t count_d;

	// Wraps silently; at line rate it would take centuries
	assign count_d = count_q + {48'h0000_0000_0000, cnt.amount};
	assign cnt.value = count_q;

	// Counter register, held at zero when not built in
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			count_q <= 64'h0000_0000_0000_0000;
		end else if (ENABLE && cnt.inc) begin
			count_q <= count_d;
		end
	end
endmodule : rx_stat_counter

// File: design/rx_mac_config_registers.sv
// Receive MAC configuration bank with Wishbone slave, frame checks and statistics
//
// Our own choice: the Wishbone slave port.
`timescale 1ns/1ps
`include "rx_mac_cfg_map.svh"

// How it works
// - Test word is read/write, resets to zero, drives nothing.
// - Three read-only words give the identifier text, four characters each, in order.
// - Sixteen-bit frame size limit, resets to 9600; longer frames count as oversized.
// - With statistics built in, each oversized frame bumps a 64-bit counter.
// - Oversized frames add nothing to the good octet count.
// - Oversized frames raise bit 3 of the per-frame error vector.
// - CRC forward control resets to 0; 0 strips CRC, 1 passes it on.
// - CRC is always checked and errors flagged, stripped or forwarded.
// - Length check enable resets to 1; then bit 4 flags payload length mismatch.
// - Fault status word exists only when link fault generation is built in.
module rx_mac_config_registers
	import rx_mac_cfg_pkg::*;
#(
	parameter bit STATS_EN      = 1'b1,
	parameter bit LINK_FAULT_EN = 1'b0
) (
	input  wire logic        i_core_clk,
	input  wire logic        i_arst_n,
	input  wire logic        i_wb_cyc,
	input  wire logic        i_wb_stb,
	input  wire logic        i_wb_we,
	input  wire logic [12:0] i_wb_adr,
	input  wire logic [3:0]  i_wb_sel,
	input  wire logic [31:0] i_wb_dat,
	output logic      [31:0] o_wb_dat,
	output logic             o_wb_ack,
	input  wire logic        i_rx_frame_done,
	input  wire logic [15:0] i_rx_frame_len,
	input  wire logic        i_rx_crc_bad,
	input  wire logic        i_rx_len_mismatch,
	input  wire logic [1:0]  i_fault_status,
	output logic      [5:0]  o_rx_error,
	output logic             o_rx_error_valid,
	output logic             o_crc_forward,
	output logic             o_irq
);
	// Reset release through two flops; assertion stays asynchronous
	logic rst_meta_q;
	logic rst_n;
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rst_meta_q <= 1'b0;
			rst_n      <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n      <= rst_meta_q;
		end
	end

	// Register state
	logic [31:0] test_q;
	logic [31:0] test_d;
	frame_len_t  max_len_q;
	frame_len_t  max_len_d;
	logic        crc_fwd_q;
	logic        crc_fwd_d;
	logic        len_chk_q;
	logic        len_chk_d;
	event_vec_t  irq_stat_q;
	event_vec_t  irq_stat_d;
	event_vec_t  irq_mask_q;
	event_vec_t  irq_mask_d;
	logic        ack_q;
	logic [31:0] rdat_q;
	rx_err_t     err_q;
	logic        err_vld_q;
	logic        irq_q;

	// Bus decode; request is taken in the cycle before ack rises
	reg_idx_t idx;
	logic     req;
	logic     wr;
	assign idx = i_wb_adr[12:2];
	assign req = i_wb_cyc && i_wb_stb && !ack_q;
	assign wr  = req && i_wb_we;

	logic hit_rev, hit_test, hit_id0, hit_id1, hit_id2, hit_max, hit_crc;
	logic hit_flt, hit_chk, hit_ol, hit_oh, hit_gl, hit_gh, hit_ist, hit_imk;
	assign hit_rev  = idx == `RXC_IDX_REVISION;
	assign hit_test = idx == `RXC_IDX_TEST_WORD;
	assign hit_id0  = idx == `RXC_IDX_IDENT_FIRST;
	assign hit_id1  = idx == `RXC_IDX_IDENT_NEXT;
	assign hit_id2  = idx == `RXC_IDX_IDENT_FINAL;
	assign hit_max  = idx == `RXC_IDX_MAX_LEN;
	assign hit_crc  = idx == `RXC_IDX_CRC_FWD;
	assign hit_flt  = (idx == `RXC_IDX_FAULT_STAT) && LINK_FAULT_EN;
	assign hit_chk  = idx == `RXC_IDX_LEN_CHECK;
	assign hit_ol   = idx == `RXC_IDX_OVR_CNT_LO;
	assign hit_oh   = idx == `RXC_IDX_OVR_CNT_HI;
	assign hit_gl   = idx == `RXC_IDX_OCT_CNT_LO;
	assign hit_gh   = idx == `RXC_IDX_OCT_CNT_HI;
	assign hit_ist  = idx == `RXC_IDX_IRQ_STATUS;
	assign hit_imk  = idx == `RXC_IDX_IRQ_MASK;

	// Byte-lane merge for 32-bit writes
	logic [31:0] lane_mask;
	assign lane_mask = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}}, {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};

	// Frame checks at end of frame
	logic oversize;
	logic len_err;
	logic good_frame;
	assign oversize   = i_rx_frame_done && (i_rx_frame_len > max_len_q);
	assign len_err    = i_rx_frame_done && i_rx_len_mismatch && len_chk_q;
	assign good_frame = i_rx_frame_done && !oversize && !i_rx_crc_bad;

	// Statistics counters
	stat_cnt_if ovr_cnt ();
	stat_cnt_if oct_cnt ();
	assign ovr_cnt.inc    = oversize;
	assign ovr_cnt.amount = 16'h0001;
	assign oct_cnt.inc    = good_frame;
	assign oct_cnt.amount = i_rx_frame_len;

	rx_stat_counter #(.ENABLE(STATS_EN)) u_ovr_cnt (
		.i_core_clk (i_core_clk),
		.i_rst_n    (rst_n),
		.cnt        (ovr_cnt)
	);
	rx_stat_counter #(.ENABLE(STATS_EN)) u_oct_cnt (
		.i_core_clk (i_core_clk),
		.i_rst_n    (rst_n),
		.cnt        (oct_cnt)
	);

	// Next values of writable registers; test word feeds no datapath
	assign test_d    = (wr && hit_test) ? ((test_q & ~lane_mask) | (i_wb_dat & lane_mask))
		: test_q;
	assign max_len_d = {(wr && hit_max && i_wb_sel[1]) ? i_wb_dat[15:8] : max_len_q[15:8],
		(wr && hit_max && i_wb_sel[0]) ? i_wb_dat[7:0] : max_len_q[7:0]};
	assign crc_fwd_d = (wr && hit_crc && i_wb_sel[0]) ? i_wb_dat[0] : crc_fwd_q;
	assign len_chk_d = (wr && hit_chk && i_wb_sel[0]) ? i_wb_dat[0] : len_chk_q;
	assign irq_mask_d = (wr && hit_imk && i_wb_sel[0]) ? i_wb_dat[2:0] : irq_mask_q;

	// Sticky events; a new event beats a write-one clear in the same cycle
	event_vec_t ev;
	event_vec_t clr;
	assign ev         = {len_err, i_rx_frame_done && i_rx_crc_bad, oversize};
	assign clr        = (wr && hit_ist && i_wb_sel[0]) ? i_wb_dat[2:0] : 3'h0;
	assign irq_stat_d = (irq_stat_q & ~clr) | ev;

	// Read mux; unassigned offsets give zero
	logic [31:0] rd_mux;
	assign rd_mux = ({32{hit_rev}}  & `RXC_REVISION_VAL)
		| ({32{hit_test}} & test_q)
		| ({32{hit_id0}}  & `RXC_IDENT_FIRST_VAL)
		| ({32{hit_id1}}  & `RXC_IDENT_NEXT_VAL)
		| ({32{hit_id2}}  & `RXC_IDENT_FINAL_VAL)
		| ({32{hit_max}}  & {16'h0000, max_len_q})
		| ({32{hit_crc}}  & {31'h0000_0000, crc_fwd_q})
		| ({32{hit_flt}}  & {30'h0000_0000, i_fault_status})
		| ({32{hit_chk}}  & {31'h0000_0000, len_chk_q})
		| ({32{hit_ol}}   & ovr_cnt.value[31:0])
		| ({32{hit_oh}}   & ovr_cnt.value[63:32])
		| ({32{hit_gl}}   & oct_cnt.value[31:0])
		| ({32{hit_gh}}   & oct_cnt.value[63:32])
		| ({32{hit_ist}}  & {29'h0000_0000, irq_stat_q})
		| ({32{hit_imk}}  & {29'h0000_0000, irq_mask_q});

	// Per-frame error vector
	rx_err_t err_d;
	assign err_d = {1'b0, len_err, oversize, 1'b0,
		i_rx_frame_done && i_rx_crc_bad, 1'b0};

	// Control and status registers
	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			test_q     <= `RXC_TEST_WORD_RST;
			max_len_q  <= `RXC_MAX_LEN_RST;
			crc_fwd_q  <= `RXC_CRC_FWD_RST;
			len_chk_q  <= `RXC_LEN_CHECK_RST;
			irq_mask_q <= `RXC_IRQ_MASK_RST;
			irq_stat_q <= 3'h0;
		end else begin
			test_q     <= test_d;
			max_len_q  <= max_len_d;
			crc_fwd_q  <= crc_fwd_d;
			len_chk_q  <= len_chk_d;
			irq_mask_q <= irq_mask_d;
			irq_stat_q <= irq_stat_d;
		end
	end

	// Bus answer: ack one cycle after the request, read data beside it
	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_q  <= 1'b0;
			rdat_q <= 32'h0000_0000;
		end else begin
			ack_q  <= req;
			rdat_q <= (req && !i_wb_we) ? rd_mux : 32'h0000_0000;
		end
	end

	// Client-facing outputs straight from flops
	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			err_q     <= 6'h00;
			err_vld_q <= 1'b0;
			irq_q     <= 1'b0;
		end else begin
			err_q     <= err_d;
			err_vld_q <= i_rx_frame_done;
			irq_q     <= |(irq_stat_d & irq_mask_d);
		end
	end

	// Forward flag taken from the next value so it follows a write without lag
	logic crc_out_q;
	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			crc_out_q <= `RXC_CRC_FWD_RST;
		end else begin
			crc_out_q <= crc_fwd_d;
		end
	end

	assign o_wb_ack         = ack_q;
	assign o_wb_dat         = rdat_q;
	assign o_rx_error       = err_q;
	assign o_rx_error_valid = err_vld_q;
	assign o_crc_forward    = crc_out_q;
	assign o_irq            = irq_q;

	// Checks
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!rst_n);

	AST_TEST_WRITE: assert property (
		wr && hit_test && (i_wb_sel == 4'hF) |=> ##1 (test_q == $past(i_wb_dat, 2)))
		else $error("test word did not take write");
	AST_IDENT_READ: assert property (
		req && !i_wb_we && hit_id1 |=> o_wb_ack && (o_wb_dat == `RXC_IDENT_NEXT_VAL))
		else $error("identifier word wrong");
	AST_MAX_LEN: assert property (
		i_rx_frame_done && (i_rx_frame_len <= max_len_q) |=> !o_rx_error[`RXC_ERR_OVERSIZE_BIT])
		else $error("in-limit frame flagged oversized");
	AST_OVR_COUNT: assert property (
		oversize && STATS_EN |=> ovr_cnt.value == $past(ovr_cnt.value) + 64'h1)
		else $error("oversize counter did not step");
	AST_OCTET_EXCL: assert property (
		oversize |=> oct_cnt.value == $past(oct_cnt.value))
		else $error("oversized octets counted");
	AST_ERR_OVERSIZE: assert property (
		i_rx_frame_done && (i_rx_frame_len > max_len_q)
		|=> o_rx_error_valid && o_rx_error[`RXC_ERR_OVERSIZE_BIT])
		else $error("oversize not flagged");
	AST_CRC_FWD: assert property (
		wr && hit_crc && i_wb_sel[0] |=> o_crc_forward == $past(i_wb_dat[0]))
		else $error("forward control not applied");
	AST_CRC_FLAG: assert property (
		i_rx_frame_done && i_rx_crc_bad |=> o_rx_error[`RXC_ERR_CRC_BIT])
		else $error("crc error not flagged");
	AST_LEN_CHECK: assert property (
		i_rx_frame_done && i_rx_len_mismatch
		|=> o_rx_error[`RXC_ERR_LENGTH_BIT] == $past(len_chk_q))
		else $error("length flag ignores enable");
	AST_FAULT_ABSENT: assert property (
		req && !i_wb_we && (idx == `RXC_IDX_FAULT_STAT) && !LINK_FAULT_EN
		|=> o_wb_dat == 32'h0000_0000)
		else $error("fault word present when not built");
	AST_UNMAPPED: assert property (
		req && !i_wb_we && (idx == 11'h505)
		|=> o_wb_ack && (o_wb_dat == 32'h0000_0000) ##1 !o_wb_ack)
		else $error("unmapped read not answered once with zero");

	// Bus handshake shape: one-cycle ack, quiet data lines between answers
	AST_ACK_PULSE: assert property (
		o_wb_ack |=> !o_wb_ack)
		else $error("ack held longer than one cycle");
	AST_RDATA_IDLE: assert property (
		!o_wb_ack |-> (o_wb_dat == 32'h0000_0000))
		else $error("read data seen without ack");

	// Control writes land at the taking edge; good octets and error valid follow one cycle after frame end
	AST_MAX_LEN_WRITE: assert property (
		wr && hit_max && (i_wb_sel[1:0] == 2'h3) |=> max_len_q == $past(i_wb_dat[15:0]))
		else $error("frame limit did not take write");
	AST_LEN_CHK_WRITE: assert property (
		wr && hit_chk && i_wb_sel[0] |=> len_chk_q == $past(i_wb_dat[0]))
		else $error("length check enable did not take write");
	AST_GOOD_OCTETS: assert property (
		good_frame && STATS_EN |=> oct_cnt.value
			== $past(oct_cnt.value) + {48'h0000_0000_0000, $past(i_rx_frame_len)})
		else $error("good octets not added");
	AST_ERR_VALID: assert property (
		i_rx_frame_done |=> o_rx_error_valid)
		else $error("error vector not marked valid");

	// Events and interrupt; an event must survive a clear in the same cycle
	AST_EVENT_WINS: assert property (
		(|ev) |=> ((irq_stat_q & $past(ev)) == $past(ev)))
		else $error("event lost to clear");
	AST_IRQ_LEVEL: assert property (
		o_irq == |(irq_stat_q & irq_mask_q))
		else $error("interrupt level disagrees with status and mask");

	COV_OVERSIZE: cover property (oversize ##1 o_rx_error_valid);
	COV_CLEAR:    cover property (wr && hit_ist ##1 !o_irq);
	COV_CRC_FWD:  cover property (wr && hit_crc ##1 o_crc_forward);
	COV_IRQ:      cover property (o_irq ##[1:20] !o_irq);
endmodule : rx_mac_config_registers

// File: verif/rx_mac_config_registers_tb_top.sv
// Self-checking bench for the receive MAC register bank
`timescale 1ns/1ps
`include "rx_mac_cfg_map.svh"
module rx_mac_config_registers_tb_top;
	import rx_mac_cfg_pkg::*;
	logic        clk = 1'b0;
	logic        arst_n = 1'b0;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [12:0] adr = 13'h0000;
	logic [3:0]  sel = 4'h0;
	logic [31:0] wdat = 32'h0000_0000;
	logic [31:0] rdat;
	logic        ack;
	logic        done = 1'b0;
	logic [15:0] flen = 16'h0000;
	logic        crc_bad = 1'b0;
	logic        mism = 1'b0;
	logic [1:0]  fault = 2'h3;
	rx_err_t     err;
	logic        err_vld;
	logic        crc_fwd;
	logic        irq;
	int          bad_count = 0;
	int          checks_done = 0;
	// Reset-time contents: index in the upper bits, expected word below
	localparam logic [42:0] ROWS [15] = '{
		{`RXC_IDX_REVISION, `RXC_REVISION_VAL}, {`RXC_IDX_TEST_WORD, 32'h0000_0000},
		{`RXC_IDX_IDENT_FIRST, `RXC_IDENT_FIRST_VAL}, {`RXC_IDX_IDENT_NEXT, `RXC_IDENT_NEXT_VAL},
		{`RXC_IDX_IDENT_FINAL, `RXC_IDENT_FINAL_VAL}, {`RXC_IDX_MAX_LEN, 32'h0000_2580},
		{`RXC_IDX_CRC_FWD, 32'h0000_0000}, {`RXC_IDX_LEN_CHECK, 32'h0000_0001},
		{`RXC_IDX_FAULT_STAT, 32'h0000_0000}, {11'h505, 32'h0000_0000},
		{`RXC_IDX_OVR_CNT_LO, 32'h0000_0000}, {`RXC_IDX_OVR_CNT_HI, 32'h0000_0000},
		{`RXC_IDX_OCT_CNT_LO, 32'h0000_0000}, {`RXC_IDX_IRQ_STATUS, 32'h0000_0000},
		{`RXC_IDX_IRQ_MASK, 32'h0000_0000}};

	always #4 clk = ~clk;

	rx_mac_config_registers rx_mac_config_registers_inst (
		.i_core_clk(clk), .i_arst_n(arst_n), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
		.i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
		.i_rx_frame_done(done), .i_rx_frame_len(flen), .i_rx_crc_bad(crc_bad),
		.i_rx_len_mismatch(mism), .i_fault_status(fault), .o_rx_error(err),
		.o_rx_error_valid(err_vld), .o_crc_forward(crc_fwd), .o_irq(irq));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic give_verdict();
		if (bad_count == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : give_verdict

	// One classic cycle; ack and data are taken at the edge that shows ack
	task automatic bus(input reg_idx_t idx, input logic w, input logic [31:0] d,
			output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= {idx, 2'b00}; sel <= 4'hF; wdat <= d;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (n >= 20) begin
			check(32'h0000_0bad, 32'h0000_0000);
			give_verdict();
		end
		q = rdat;
		cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
	endtask : bus

	task automatic wr(input reg_idx_t idx, input logic [31:0] d);
		logic [31:0] q;
		bus(idx, 1'b1, d, q);
	endtask : wr

	task automatic rd(input reg_idx_t idx, input logic [31:0] exp);
		logic [31:0] q;
		bus(idx, 1'b0, 32'h0000_0000, q);
		check(q, exp);
	endtask : rd

	// Frame end pulse; error vector checked in the cycle it is valid
	task automatic frame(input frame_len_t l, input logic c, input logic m, input rx_err_t e);
		@(posedge clk);
		done <= 1'b1; flen <= l; crc_bad <= c; mism <= m;
		@(posedge clk);
		done <= 1'b0; crc_bad <= 1'b0; mism <= 1'b0;
		#1;
		check({31'h0, err_vld}, 32'h0000_0001);
		check({26'h0, err}, {26'h0, e});
	endtask : frame

	// Watchdog sized well above the expected run of about 140 cycles
	initial begin
		#(8 * 5000);
		bad_count++;
		give_verdict();
	end

	initial begin
		repeat (4) @(posedge clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
		foreach (ROWS[i]) rd(ROWS[i][42:32], ROWS[i][31:0]);
		check({31'h0, crc_fwd}, 32'h0000_0000);
		// Hand-written cases: writes, read-only and unmapped places
		wr(`RXC_IDX_TEST_WORD, 32'hA5A5_5A5A);
		rd(`RXC_IDX_TEST_WORD, 32'hA5A5_5A5A);
		wr(`RXC_IDX_REVISION, 32'hFFFF_FFFF);
		rd(`RXC_IDX_REVISION, `RXC_REVISION_VAL);
		wr(11'h505, 32'h1234_5678);
		rd(11'h505, 32'h0000_0000);
		wr(`RXC_IDX_CRC_FWD, 32'h0000_0001);
		rd(`RXC_IDX_CRC_FWD, 32'h0000_0001);
		check({31'h0, crc_fwd}, 32'h0000_0001);
		// Limit at 100: 101 is oversized, 100 is not
		wr(`RXC_IDX_MAX_LEN, 32'h0000_0064);
		frame(16'd101, 1'b0, 1'b0, 6'h08);
		frame(16'd100, 1'b0, 1'b0, 6'h00);
		frame(16'd100, 1'b1, 1'b0, 6'h02);
		wr(`RXC_IDX_CRC_FWD, 32'h0000_0000);
		check({31'h0, crc_fwd}, 32'h0000_0000);
		frame(16'd100, 1'b1, 1'b0, 6'h02);
		frame(16'd100, 1'b0, 1'b1, 6'h10);
		rd(`RXC_IDX_OVR_CNT_LO, 32'h0000_0001);
		rd(`RXC_IDX_OCT_CNT_LO, 32'h0000_00C8);
		wr(`RXC_IDX_LEN_CHECK, 32'h0000_0000);
		frame(16'd100, 1'b0, 1'b1, 6'h00);
		// Sticky events, masking and write-one clear
		rd(`RXC_IDX_IRQ_STATUS, 32'h0000_0007);
		check({31'h0, irq}, 32'h0000_0000);
		wr(`RXC_IDX_IRQ_MASK, 32'h0000_0001);
		rd(`RXC_IDX_IRQ_MASK, 32'h0000_0001);
		check({31'h0, irq}, 32'h0000_0001);
		wr(`RXC_IDX_IRQ_STATUS, 32'h0000_0001);
		rd(`RXC_IDX_IRQ_STATUS, 32'h0000_0006);
		check({31'h0, irq}, 32'h0000_0000);
		// Mid-run reset must bring test word, frame limit, length check, CRC forward and oversize count back to reset values
		wr(`RXC_IDX_CRC_FWD, 32'h0000_0001);
		arst_n <= 1'b0;
		repeat (2) @(posedge clk);
		check({31'h0, crc_fwd}, 32'h0000_0000);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
		rd(`RXC_IDX_TEST_WORD, 32'h0000_0000);
		rd(`RXC_IDX_MAX_LEN, 32'h0000_2580);
		rd(`RXC_IDX_LEN_CHECK, 32'h0000_0001);
		rd(`RXC_IDX_CRC_FWD, 32'h0000_0000);
		rd(`RXC_IDX_OVR_CNT_LO, 32'h0000_0000);
		give_verdict();
	end
endmodule : rx_mac_config_registers_tb_top
